// ===== rtl/pbrc_boot_reset.v
`timescale 1ns/1ns
`default_nettype none
`include "pbrc_regs.vh"

// Behaviour
// - Strap 0 uses region 0x00-0x2F selector 0; strap 1 uses 0x30-0x5F selector 1.
// - Strap level latched when an off-to-active started from off completes (not after warm reset), held in boot status.
// - Strap acts as static branch selector during sequence; stored sequence untouched.
// - Sequence is an ordered series of register writes to resources.
// - Host writes accepted after sequence completes, overwriting sequence settings.
// - Static settings are init values; dynamic updates from host or sequence.
// - Each resource register belongs to power-on, hardware or switch-off domain.
// - Power-on reset clears all three domains.
// - Power-on domain keeps its contents through hardware and switch-off resets.
// - Off request set for hardware reset runs shutdown from active or sleep.
// - Hardware reset clears hardware and switch-off domains, keeps power-on.
// - Hardware domain holds non-mode regulator fields, config, interrupts and more.
// - Off request without hardware reset runs shutdown, clears switch-off domain only.
// - Switch-off domain holds voltage, mode, device control, monitor, watchdog fields.
// - Interrupt output is push-pull active low, low while unmasked interrupt pending.
// - Interrupt output masked in sleep by default; a bit controls this.
// - Each interrupt source has its own mask.
// - Warm reset pin runs off-to-active from active or sleep, ends active.
// - Resources outside off-to-active keep their state during warm reset.
// - Warm reset: sequenced resources go active; per-resource bit reloads or keeps voltage.
// - Reset input triggers cold reset or shutdown, debounced 1 ms either polarity.
// - After entering off, reset input ignored for 25 ms.
// - Processor reset output held until power-up sequence completes.
module pbrc_boot_reset #(
	parameter NRES        = 8,
	parameter DEBOUNCE_CYC = `PBRC_DEBOUNCE_CYC,
	parameter MASK_CYC     = `PBRC_MASK_CYC,
	parameter NINT        = 8
) (
	input  wire                    clk_sys,
	input  wire                    reset,
	input  wire                    boot_strap,
	input  wire                    on_request,
	input  wire                    off_request,
	input  wire                    sleep_request,
	input  wire                    wake_request,
	input  wire [7:0]              off_request_reset_level_reg,
	input  wire                    warm_reset_pin_n,
	input  wire                    reset_in,
	input  wire                    reset_in_polarity,
	input  wire                    reset_in_cold,
	input  wire                    mem_load_en,
	input  wire [6:0]              mem_load_addr,
	input  wire [18:0]             mem_load_data,
	input  wire [NRES*8-1:0]       static_defaults,
	input  wire                    host_wr_en,
	input  wire [1:0]              host_wr_domain,
	input  wire [7:0]              host_wr_index,
	input  wire [7:0]              host_wr_data,
	input  wire [NRES-1:0]         warm_reload_sel,
	input  wire [NRES-1:0]         seq_member,
	input  wire [NINT-1:0]         int_source,
	input  wire [NINT-1:0]         int_clear,
	input  wire [NINT-1:0]         int_mask,
	input  wire                    int_mask_in_sleep,
	output reg                     boot_status_reg,
	output wire                    seq_selector,
	output reg  [NRES*8-1:0]       por_domain_reg,
	output reg  [NRES*8-1:0]       hw_domain_reg,
	output reg  [NRES*8-1:0]       swo_domain_reg,
	output reg  [7:0]              shutdown_cause_reg,
	output reg  [NINT-1:0]         int_pending_reg,
	output wire                    int_n,
	output reg                     reset_out_n_reg,
	output reg                     seq_busy_reg,
	output reg                     hard_reset_event,
	output reg                     switchoff_reset_event,
	output reg  [2:0]              power_state_reg
);

	// Power states, one-hot
	localparam [2:0] ST_OFF    = 3'b001;
	localparam [2:0] ST_ACTIVE = 3'b010;
	localparam [2:0] ST_SLEEP  = 3'b100;

	// Sequencer states, one-hot
	localparam [3:0] SQ_IDLE  = 4'b0001;
	localparam [3:0] SQ_FETCH = 4'b0010;
	localparam [3:0] SQ_WAIT  = 4'b0100;
	localparam [3:0] SQ_EXEC  = 4'b1000;

	// Sequence kinds
	localparam [1:0] K_UP   = 2'd0;
	localparam [1:0] K_DOWN = 2'd1;
	localparam [1:0] K_WARM = 2'd2;

	localparam [1:0] DOM_POR = 2'd0;
	localparam [1:0] DOM_HW  = 2'd1;
	localparam [1:0] DOM_SWO = 2'd2;

	localparam [6:0] DOWN_OFS = 7'h18;

	// Region base for a strap level
	function [6:0] region_base;
		input sel;
		begin
			region_base = sel ? `PBRC_REGION1_FIRST : `PBRC_REGION0_FIRST;
		end
	endfunction

	// Region end for a strap level
	function [6:0] region_last;
		input sel;
		begin
			region_last = sel ? `PBRC_REGION1_LAST : `PBRC_REGION0_LAST;
		end
	endfunction

	reg  [3:0]  sq_reg;
	reg  [1:0]  kind_reg;
	reg  [6:0]  pc_reg;
	reg  [6:0]  pc_last_reg;
	reg         off_hw_reg;
	reg  [7:0]  cause_next;
	wire [18:0] ins;
	wire        ins_last;
	wire        ins_skip;
	wire [7:0]  ins_tgt;
	wire [7:0]  ins_val;
	wire        seq_wr;
	wire        seq_done;

	// Strap is the static selector for region and branches
	assign seq_selector = boot_strap;

	pbrc_seq_mem #(
		.ADDR_W (`PBRC_ADDR_W),
		.DATA_W (`PBRC_INS_W)
	) u_mem (
		.clk_sys (clk_sys),
		.wr_en   (mem_load_en),
		.wr_addr (mem_load_addr),
		.wr_data (mem_load_data),
		.rd_addr (pc_reg),
		.rd_data (ins)
	);

	// Instruction decode; branch skips when selector mismatches
	assign ins_last = ins[`PBRC_INS_LAST];
	assign ins_skip = ins[`PBRC_INS_BVALID] & (ins[`PBRC_INS_BSEL] != boot_strap);
	assign ins_tgt  = ins[`PBRC_INS_TGT_HI:`PBRC_INS_TGT_LO];
	assign ins_val  = ins[`PBRC_INS_VAL_HI:`PBRC_INS_VAL_LO];
	assign seq_wr   = (sq_reg == SQ_EXEC) & ~ins_skip;
	assign seq_done = (sq_reg == SQ_EXEC) & (ins_last | (pc_reg == pc_last_reg));

	// Reset input debounce and mask after off
	reg         rin_stable_reg;
	reg  [31:0] db_cnt_reg;
	reg  [31:0] mask_cnt_reg;
	wire        rin_level = reset_in ^ ~reset_in_polarity;
	wire        rin_event;

	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rin_stable_reg <= 1'b0;
			db_cnt_reg     <= 32'h00000000;
		end else if (rin_level == rin_stable_reg) begin
			db_cnt_reg <= 32'h00000000;
		end else if (db_cnt_reg >= DEBOUNCE_CYC - 1) begin
			rin_stable_reg <= rin_level;
			db_cnt_reg     <= 32'h00000000;
		end else begin
			db_cnt_reg <= db_cnt_reg + 32'h00000001;
		end
	end

	// Mask window counts down after entering off
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			mask_cnt_reg <= 32'h00000000;
		end else if (seq_done && kind_reg == K_DOWN) begin
			mask_cnt_reg <= MASK_CYC;
		end else if (mask_cnt_reg != 32'h00000000) begin
			mask_cnt_reg <= mask_cnt_reg - 32'h00000001;
		end
	end

	reg rin_prev_reg;
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rin_prev_reg <= 1'b0;
		end else begin
			rin_prev_reg <= rin_stable_reg;
		end
	end
	assign rin_event = rin_stable_reg & ~rin_prev_reg & (mask_cnt_reg == 32'h00000000);

	// Warm reset pin edge
	reg  warm_prev_reg;
	wire warm_event = ~warm_reset_pin_n & warm_prev_reg;
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			warm_prev_reg <= 1'b1;
		end else begin
			warm_prev_reg <= warm_reset_pin_n;
		end
	end

	// Shutdown request and its reset level
	wire off_any = off_request | (rin_event & ~power_state_reg[0]);
	wire off_hw  = rin_event ? reset_in_cold : off_request_reset_level_reg[0];

	// Power state machine and sequencer
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			power_state_reg <= ST_OFF;
			sq_reg          <= SQ_IDLE;
			kind_reg        <= K_UP;
			pc_reg          <= 7'h00;
			pc_last_reg     <= 7'h00;
			off_hw_reg      <= 1'b0;
			seq_busy_reg    <= 1'b0;
		end else begin
			case (sq_reg)
				SQ_IDLE: begin
					if (power_state_reg == ST_OFF && on_request) begin
						kind_reg     <= K_UP;
						pc_reg       <= region_base(boot_strap);
						pc_last_reg  <= region_last(boot_strap);
						sq_reg       <= SQ_FETCH;
						seq_busy_reg <= 1'b1;
					end else if (power_state_reg != ST_OFF && warm_event) begin
						kind_reg     <= K_WARM;
						pc_reg       <= region_base(boot_strap);
						pc_last_reg  <= region_last(boot_strap);
						sq_reg       <= SQ_FETCH;
						seq_busy_reg <= 1'b1;
					end else if (power_state_reg != ST_OFF && off_any) begin
						kind_reg     <= K_DOWN;
						off_hw_reg   <= off_hw;
						pc_reg       <= region_base(boot_strap) + DOWN_OFS;
						pc_last_reg  <= region_last(boot_strap);
						sq_reg       <= SQ_FETCH;
						seq_busy_reg <= 1'b1;
					end else if (power_state_reg == ST_ACTIVE && sleep_request) begin
						power_state_reg <= ST_SLEEP;
					end else if (power_state_reg == ST_SLEEP && wake_request) begin
						power_state_reg <= ST_ACTIVE;
					end
				end
				SQ_FETCH: begin
					sq_reg <= SQ_WAIT;
				end
				SQ_WAIT: begin
					sq_reg <= SQ_EXEC;
				end
				SQ_EXEC: begin
					if (seq_done) begin
						sq_reg       <= SQ_IDLE;
						seq_busy_reg <= 1'b0;
						power_state_reg <= (kind_reg == K_DOWN) ? ST_OFF : ST_ACTIVE;
					end else begin
						pc_reg <= pc_reg + 7'h01;
						sq_reg <= SQ_FETCH;
					end
				end
				default: begin
					sq_reg <= SQ_IDLE;
				end
			endcase
		end
	end

	// Reset events pulse at the end of a shutdown
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			hard_reset_event      <= 1'b0;
			switchoff_reset_event <= 1'b0;
		end else begin
			hard_reset_event      <= seq_done & (kind_reg == K_DOWN) & off_hw_reg;
			switchoff_reset_event <= seq_done & (kind_reg == K_DOWN) & ~off_hw_reg;
		end
	end

	// Boot status latched at end of off-to-active started from off, not after warm reset
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			boot_status_reg <= 1'b0;
		end else if (seq_done && kind_reg == K_UP) begin
			boot_status_reg <= boot_strap;
		end
	end

	// Processor reset held through power-up
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			reset_out_n_reg <= 1'b0;
		end else if (seq_done && kind_reg != K_DOWN) begin
			reset_out_n_reg <= 1'b1;
		end else if (sq_reg == SQ_IDLE && power_state_reg == ST_OFF) begin
			reset_out_n_reg <= 1'b0;
		end
	end

	// Three reset domains, one byte per resource
	wire host_ok = host_wr_en & ~seq_busy_reg;
	genvar g;
	generate
		for (g = 0; g < NRES; g = g + 1) begin : g_res
			wire [7:0] def  = static_defaults[g*8 +: 8];
			wire       hsel = host_ok & (host_wr_index == g);
			wire       ssel = seq_wr & (ins_tgt == g);
			wire       wsel = (kind_reg == K_WARM) & seq_busy_reg & seq_member[g];

			// Power-on domain: only the global reset clears it
			always @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					por_domain_reg[g*8 +: 8] <= `PBRC_RST_POR;
				end else if (hsel && host_wr_domain == DOM_POR) begin
					por_domain_reg[g*8 +: 8] <= host_wr_data;
				end
			end

			// Hardware domain, cleared by hardware reset to static defaults
			always @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					hw_domain_reg[g*8 +: 8] <= `PBRC_RST_HW;
				end else if (hard_reset_event) begin
					hw_domain_reg[g*8 +: 8] <= def;
				end else if (hsel && host_wr_domain == DOM_HW) begin
					hw_domain_reg[g*8 +: 8] <= host_wr_data;
				end
			end

			// Switch-off domain: voltage and mode, cleared by either off reset
			always @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					swo_domain_reg[g*8 +: 8] <= `PBRC_RST_SWO;
				end else if (hard_reset_event || switchoff_reset_event) begin
					swo_domain_reg[g*8 +: 8] <= def;
				end else if (wsel && sq_reg == SQ_FETCH && warm_reload_sel[g]) begin
					swo_domain_reg[g*8 +: 8] <= def;
				end else if (ssel) begin
					swo_domain_reg[g*8 +: 8] <= ins_val;
				end else if (hsel && host_wr_domain == DOM_SWO) begin
					swo_domain_reg[g*8 +: 8] <= host_wr_data;
				end
			end
		end
	endgenerate

	// Shutdown cause, power-on domain, sticky
	always @* begin
		cause_next = shutdown_cause_reg;
		if (host_ok && host_wr_domain == DOM_POR && host_wr_index == 8'hFF) begin
			cause_next = cause_next & ~host_wr_data;
		end
		if (rin_event) begin
			cause_next[`PBRC_CAUSE_RESET_IN] = 1'b1;
		end
		if (off_request) begin
			cause_next[`PBRC_CAUSE_HOST_OFF] = 1'b1;
		end
		if (warm_event) begin
			cause_next[`PBRC_CAUSE_WARM] = 1'b1;
		end
	end

	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			shutdown_cause_reg <= `PBRC_RST_POR;
		end else begin
			shutdown_cause_reg <= cause_next;
		end
	end

	// Pending interrupts, hardware domain; set wins over clear
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			int_pending_reg <= {NINT{1'b0}};
		end else if (hard_reset_event) begin
			int_pending_reg <= {NINT{1'b0}};
		end else begin
			int_pending_reg <= (int_pending_reg & ~int_clear) | int_source;
		end
	end

	// Active-low push-pull interrupt with per-source and sleep masks
	assign int_n = ~(|(int_pending_reg & ~int_mask)
		& ~(int_mask_in_sleep & power_state_reg[2]));

endmodule // pbrc_boot_reset

`default_nettype wire

// ===== rtl/pbrc_regs.vh
`ifndef PBRC_REGS_VH
`define PBRC_REGS_VH

// Stored configuration regions picked by the boot strap
`define PBRC_REGION0_FIRST   7'h00
`define PBRC_REGION0_LAST    7'h2F
`define PBRC_REGION1_FIRST   7'h30
`define PBRC_REGION1_LAST    7'h5F
`define PBRC_ADDR_W          7

// Timing, clock rate and derived cycle counts
`define PBRC_CLK_HZ          10000000
`define PBRC_DEBOUNCE_US     1000
`define PBRC_MASK_US         25000
`define PBRC_DEBOUNCE_CYC    ((`PBRC_DEBOUNCE_US * (`PBRC_CLK_HZ / 1000000)))
`define PBRC_MASK_CYC        ((`PBRC_MASK_US * (`PBRC_CLK_HZ / 1000000)))

// Reset values of the domain registers
`define PBRC_RST_POR         8'h00
`define PBRC_RST_HW          8'h00
`define PBRC_RST_SWO         8'h00
`define PBRC_RST_INTMASK     8'h00
`define PBRC_RST_LEVEL_REG   8'hFF

// Shutdown cause bit positions
`define PBRC_CAUSE_RESET_IN  0
`define PBRC_CAUSE_HOST_OFF  1
`define PBRC_CAUSE_WARM      2

// Sequence instruction fields: {last, branch_sel_valid, branch_sel, target, value}
`define PBRC_INS_W           19
`define PBRC_INS_LAST        18
`define PBRC_INS_BVALID      17
`define PBRC_INS_BSEL        16
`define PBRC_INS_TGT_HI      15
`define PBRC_INS_TGT_LO      8
`define PBRC_INS_VAL_HI      7
`define PBRC_INS_VAL_LO      0

`endif

// ===== rtl/pbrc_seq_mem.v
`timescale 1ns/1ns
`default_nettype none

// Sequence store with registered read data
module pbrc_seq_mem #(
	parameter ADDR_W = 7,
	parameter DATA_W = 19
) (
	input  wire              clk_sys,
	input  wire              wr_en,
	input  wire [ADDR_W-1:0] wr_addr,
	input  wire [DATA_W-1:0] wr_data,
	input  wire [ADDR_W-1:0] rd_addr,
	output reg  [DATA_W-1:0] rd_data
);

	reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	// Load port and registered read
	always @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule // pbrc_seq_mem

`default_nettype wire

// ===== dv/pbrc_boot_reset_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module pbrc_boot_reset_assertions #(
	parameter NRES = 8,
	parameter NINT = 8
) (
	input wire logic              clk_sys,
	input wire logic              reset,
	input wire logic              boot_strap,
	input wire logic [NRES*8-1:0] static_defaults,
	input wire logic [NINT-1:0]   int_mask,
	input wire logic              int_mask_in_sleep,
	input wire logic              boot_status_reg,
	input wire logic              seq_selector,
	input wire logic [NRES*8-1:0] por_domain_reg,
	input wire logic [NRES*8-1:0] hw_domain_reg,
	input wire logic [NRES*8-1:0] swo_domain_reg,
	input wire logic [NINT-1:0]   int_pending_reg,
	input wire logic              int_n,
	input wire logic              reset_out_n_reg,
	input wire logic              seq_busy_reg,
	input wire logic              hard_reset_event,
	input wire logic              switchoff_reset_event,
	input wire logic [2:0]        power_state_reg
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic from_off;
	// Remembers whether the running sequence started from off
	always @(posedge clk_sys or posedge reset) begin
		if (reset)
			from_off <= 1'b0;
		else if ($rose(seq_busy_reg))
			from_off <= (power_state_reg == 3'b001);
	end
	chk_int_level: assert property (int_n == !((|(int_pending_reg & ~int_mask))
		&& !(power_state_reg == 3'b100 && int_mask_in_sleep))) else $error("interrupt output level wrong");
	chk_selector_strap: assert property (seq_selector == boot_strap)
		else $error("sequence selector does not follow strap");
	chk_rst_release: assert property ($rose(reset_out_n_reg) |-> $past(seq_busy_reg))
		else $error("reset output released outside sequence end");
	chk_boot_latch: assert property ($fell(seq_busy_reg) && from_off |=> boot_status_reg == $past(boot_strap))
		else $error("boot status not latched");
	chk_event_off: assert property (hard_reset_event || switchoff_reset_event |-> ##[0:2]
		(power_state_reg == 3'b001 && swo_domain_reg == static_defaults)) else $error("off event without off state");
	chk_hw_clear: assert property (hard_reset_event |-> ##[0:2] hw_domain_reg == static_defaults)
		else $error("hardware domain not cleared");
	chk_por_keep: assert property (hard_reset_event || switchoff_reset_event |=> $stable(por_domain_reg) [*2])
		else $error("power-on domain changed");
	chk_swo_only: assert property (switchoff_reset_event |=> $stable(hw_domain_reg) [*2])
		else $error("hardware domain changed on switch-off reset");
	cov_hard: cover property (hard_reset_event);
	cov_swo: cover property (switchoff_reset_event);
	cov_int: cover property ($fell(int_n));
endmodule // pbrc_boot_reset_assertions
bind pbrc_boot_reset pbrc_boot_reset_assertions #(.NRES(NRES), .NINT(NINT)) chk_u (
	.clk_sys(clk_sys), .reset(reset), .boot_strap(boot_strap), .static_defaults(static_defaults),
	.int_mask(int_mask), .int_mask_in_sleep(int_mask_in_sleep), .boot_status_reg(boot_status_reg),
	.seq_selector(seq_selector), .por_domain_reg(por_domain_reg), .hw_domain_reg(hw_domain_reg),
	.swo_domain_reg(swo_domain_reg), .int_pending_reg(int_pending_reg), .int_n(int_n),
	.reset_out_n_reg(reset_out_n_reg), .seq_busy_reg(seq_busy_reg), .hard_reset_event(hard_reset_event),
	.switchoff_reset_event(switchoff_reset_event), .power_state_reg(power_state_reg));
`default_nettype wire

// ===== dv/pbrc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module pbrc_host_model (
	input  wire logic clk_sys,
	input  wire logic seq_busy_reg,
	output var  logic on_request,
	output var  logic off_request,
	output var  logic sleep_request,
	output var  logic wake_request,
	output var  logic warm_reset_pin_n
);
	// Idle levels: no request, warm pin released
	initial begin
		on_request = 1'b0;
		off_request = 1'b0;
		sleep_request = 1'b0;
		wake_request = 1'b0;
		warm_reset_pin_n = 1'b1;
	end
	// Holds one request until the sequencer answers busy or 60 cycles pass
	task automatic request(input int kind);
		int n;
		n = 0;
		@(posedge clk_sys);
		case (kind)
			0: on_request <= 1'b1;
			1: off_request <= 1'b1;
			2: sleep_request <= 1'b1;
			3: wake_request <= 1'b1;
			default: warm_reset_pin_n <= 1'b0;
		endcase
		do begin
			@(negedge clk_sys);
			n++;
		end while (seq_busy_reg !== 1'b1 && n < 60);
		@(posedge clk_sys);
		on_request <= 1'b0;
		off_request <= 1'b0;
		sleep_request <= 1'b0;
		wake_request <= 1'b0;
		warm_reset_pin_n <= 1'b1;
	endtask
endmodule // pbrc_host_model
`default_nettype wire

// ===== dv/pbrc_tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	localparam [63:0] DEFS = 64'h8877665544332211;
	logic        clk_sys = 1'b0, reset = 1'b1, boot_strap = 1'b0, reset_in = 1'b0, reset_in_cold = 1'b1;
	logic        mem_load_en = 1'b0, host_wr_en = 1'b0, int_mask_in_sleep = 1'b1, busy_d = 1'b0, done_d = 1'b0;
	logic [7:0]  level_reg = 8'h00, host_wr_index = 8'h00, host_wr_data = 8'h00, r0, r1, r2, src;
	logic [7:0]  int_source = 8'h00, int_clear = 8'h00, int_mask = 8'h00;
	logic [7:0]  seq_member = 8'h00, warm_reload_sel = 8'h00;
	logic        reset_in_pol = 1'b1;
	logic [6:0]  mem_load_addr = 7'h00;
	logic [18:0] mem_load_data = 19'h00000;
	logic [1:0]  host_wr_domain = 2'h0;
	logic [3:0]  seq_q[$], note;
	logic        ev_q[$];
	int          n_mismatch = 0, checks = 0, cycles = 0, run_len = 0, last_len = 0, len0 = 0;
	wire         on_request, off_request, sleep_request, wake_request, warm_reset_pin_n;
	wire         boot_status_reg, seq_selector, int_n, reset_out_n_reg, seq_busy_reg, hard_ev, swo_ev;
	wire [63:0]  por_domain_reg, hw_domain_reg, swo_domain_reg;
	wire [7:0]   shutdown_cause_reg, int_pending_reg;
	wire [2:0]   power_state_reg;
	pbrc_boot_reset #(.DEBOUNCE_CYC(4), .MASK_CYC(40)) dut_u (.clk_sys(clk_sys), .reset(reset),
		.boot_strap(boot_strap), .on_request(on_request), .off_request(off_request),
		.sleep_request(sleep_request), .wake_request(wake_request), .off_request_reset_level_reg(level_reg),
		.warm_reset_pin_n(warm_reset_pin_n), .reset_in(reset_in), .reset_in_polarity(reset_in_pol),
		.reset_in_cold(reset_in_cold), .mem_load_en(mem_load_en), .mem_load_addr(mem_load_addr),
		.mem_load_data(mem_load_data), .static_defaults(DEFS), .host_wr_en(host_wr_en),
		.host_wr_domain(host_wr_domain), .host_wr_index(host_wr_index), .host_wr_data(host_wr_data),
		.warm_reload_sel(warm_reload_sel), .seq_member(seq_member), .int_source(int_source), .int_clear(int_clear),
		.int_mask(int_mask), .int_mask_in_sleep(int_mask_in_sleep), .boot_status_reg(boot_status_reg),
		.seq_selector(seq_selector), .por_domain_reg(por_domain_reg), .hw_domain_reg(hw_domain_reg),
		.swo_domain_reg(swo_domain_reg), .shutdown_cause_reg(shutdown_cause_reg),
		.int_pending_reg(int_pending_reg), .int_n(int_n), .reset_out_n_reg(reset_out_n_reg),
		.seq_busy_reg(seq_busy_reg), .hard_reset_event(hard_ev), .switchoff_reset_event(swo_ev),
		.power_state_reg(power_state_reg));
	pbrc_host_model host_u (.clk_sys(clk_sys), .seq_busy_reg(seq_busy_reg), .on_request(on_request),
		.off_request(off_request), .sleep_request(sleep_request), .wake_request(wake_request),
		.warm_reset_pin_n(warm_reset_pin_n));
	// 10 MHz clock
	always #50 clk_sys = ~clk_sys;
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			complete_run();
		end
	end
	// Monitor: each finished sequence and each reset event takes the oldest note
	always @(negedge clk_sys) begin
		if (seq_busy_reg === 1'b1)
			run_len++;
		if (done_d) begin
			note = (seq_q.size() > 0) ? seq_q.pop_front() : 4'hF;
			check("end_state", power_state_reg, note[2:0]);
			check("boot_status", boot_status_reg, note[3]);
		end
		done_d = (busy_d === 1'b1) && (seq_busy_reg === 1'b0);
		if (done_d) begin
			last_len = run_len;
			run_len = 0;
		end
		busy_d = seq_busy_reg;
		if (hard_ev === 1'b1 || swo_ev === 1'b1)
			check("event_kind", hard_ev, (ev_q.size() > 0) ? ev_q.pop_front() : 1'bx);
	end
	task automatic hwrite(input logic [1:0] d, input logic [7:0] i, input logic [7:0] v);
		@(posedge clk_sys);
		host_wr_en <= 1'b1;
		host_wr_domain <= d;
		host_wr_index <= i;
		host_wr_data <= v;
		@(posedge clk_sys);
		host_wr_en <= 1'b0;
	endtask
	task automatic pulse_int(input logic [7:0] s, input logic [7:0] c);
		@(posedge clk_sys);
		int_source <= s;
		int_clear <= c;
		@(posedge clk_sys);
		int_source <= 8'h00;
		int_clear <= 8'h00;
		repeat (2) @(negedge clk_sys);
	endtask
	task automatic run_seq;
		int n;
		n = 0;
		while (seq_busy_reg !== 1'b1 && n < 60) begin
			@(negedge clk_sys);
			n++;
		end
		while (seq_busy_reg !== 1'b0 && n < 120) begin
			@(negedge clk_sys);
			n++;
		end
		repeat (3) @(negedge clk_sys);
	endtask
	task automatic go(input int kind, input logic [3:0] exp);
		seq_q.push_back(exp);
		host_u.request(kind);
		run_seq();
	endtask
	initial begin
		void'($urandom(32'h74fc));
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		// Region 0 holds two instructions, region 1 one
		for (int a = 0; a < 96; a++) begin
			@(posedge clk_sys);
			mem_load_en <= 1'b1;
			mem_load_addr <= a[6:0];
			mem_load_data <= (a == 0) ? 19'h0F000 : 19'h4F000;
		end
		@(posedge clk_sys);
		mem_load_en <= 1'b0;
		@(negedge clk_sys);
		check("state", power_state_reg, 3'b001);
		check("por", por_domain_reg, 64'h0);
		check("hw", hw_domain_reg, 64'h0);
		check("rst_out", reset_out_n_reg, 1'b0);
		go(0, 4'b0010);
		len0 = last_len;
		check("rst_out", reset_out_n_reg, 1'b1);
		r0 = $urandom;
		r1 = $urandom;
		r2 = $urandom;
		hwrite(2'd0, 8'h03, r0);
		hwrite(2'd1, 8'h05, r1);
		hwrite(2'd2, 8'h06, r2);
		@(negedge clk_sys);
		check("por_wr", por_domain_reg[31:24], r0);
		check("hw_wr", hw_domain_reg[47:40], r1);
		check("swo_wr", swo_domain_reg[55:48], r2);
		$display("test boot and writes done");
		ev_q.push_back(1'b0);
		go(1, 4'b0001);
		check("por_keep", por_domain_reg[31:24], r0);
		check("hw_keep", hw_domain_reg[47:40], r1);
		check("cause_off", shutdown_cause_reg[1], 1'b1);
		boot_strap <= 1'b1;
		go(0, 4'b1010);
		check("region_len", len0 - last_len, 3);
		$display("test switch-off and strap done");
		int_mask <= $urandom;
		src = $urandom;
		pulse_int(src, 8'h00);
		check("int_masked", int_n, ~|(src & ~int_mask));
		pulse_int(8'h00, 8'hFF);
		check("int_clear", int_n, 1'b1);
		host_u.request(2);
		@(negedge clk_sys);
		check("sleep_state", power_state_reg, 3'b100);
		int_mask <= 8'h00;
		pulse_int(8'h01, 8'h00);
		check("int_sleep", int_n, 1'b1);
		int_mask_in_sleep <= 1'b0;
		@(negedge clk_sys);
		check("int_sleep", int_n, 1'b0);
		host_u.request(3);
		@(negedge clk_sys);
		check("wake_state", power_state_reg, 3'b010);
		pulse_int(8'h00, 8'hFF);
		$display("test interrupts done");
		hwrite(2'd1, 8'h02, r0);
		hwrite(2'd2, 8'h02, r0);
		hwrite(2'd2, 8'h05, r1);
		hwrite(2'd2, 8'h06, r2);
		seq_member <= 8'h60;
		warm_reload_sel <= 8'h44;
		go(4, 4'b1010);
		check("warm_keep", hw_domain_reg[23:16], r0);
		check("warm_nonmember", swo_domain_reg[23:16], r0);
		check("warm_kept", swo_domain_reg[47:40], r1);
		check("warm_reload", swo_domain_reg[55:48], DEFS[55:48]);
		level_reg <= 8'h01;
		ev_q.push_back(1'b1);
		go(1, 4'b1001);
		check("hw_clr", hw_domain_reg, DEFS);
		check("por_keep", por_domain_reg[31:24], r0);
		$display("test warm and hard reset done");
		go(0, 4'b1010);
		// Let the mask window from the last shutdown run out first
		repeat (40) @(negedge clk_sys);
		reset_in <= 1'b1;
		repeat (2) @(negedge clk_sys);
		reset_in <= 1'b0;
		repeat (10) @(negedge clk_sys);
		check("glitch", power_state_reg, 3'b010);
		reset_in <= 1'b1;
		ev_q.push_back(1'b1);
		seq_q.push_back(4'b1001);
		run_seq();
		check("cause_rin", shutdown_cause_reg[0], 1'b1);
		reset_in <= 1'b0;
		repeat (6) @(negedge clk_sys);
		go(0, 4'b1010);
		reset_in <= 1'b1;
		repeat (12) @(negedge clk_sys);
		check("masked", power_state_reg, 3'b010);
		// Switch to active-low input, idle level high
		reset_in_pol <= 1'b0;
		reset_in <= 1'b1;
		repeat (45) @(negedge clk_sys);
		reset_in_cold <= 1'b0;
		reset_in <= 1'b0;
		ev_q.push_back(1'b0);
		seq_q.push_back(4'b1001);
		run_seq();
		check("notes_left", seq_q.size() + ev_q.size(), 0);
		$display("test reset input done");
		complete_run();
	end
endmodule // tb
`default_nettype wire
